//--- verilog/coarse_modulator.sv
`timescale 1ns/10ps
module coarse_modulator (
  mod_link_if.dev link,
  output logic [13:0] dac_i,
  output logic [13:0] dac_q,
  output logic sample_taken
);
  // ----------------------------------------------------------------
  // arithmetic helpers
  // ----------------------------------------------------------------
  function automatic logic [13:0] sat(input logic signed [31:0] v);
    if (v > mod_pkg::SAT_MAX) begin
      return 14'h1fff;
    end else if (v < mod_pkg::SAT_MIN) begin
      return 14'h2000;
    end
    return v[13:0];
  endfunction : sat
  function automatic logic signed [31:0] sx(input logic [13:0] a);
    return {{18{a[13]}}, a};
  endfunction : sx
  // negation saturates so that the most negative code cannot wrap
  function automatic logic [13:0] neg(input logic [13:0] a);
    return sat(-sx(a));
  endfunction : neg
  function automatic logic [13:0] rmul(input logic signed [31:0] s);
    logic signed [31:0] p;
    p = s * 32'(mod_pkg::R_COEF) + mod_pkg::R_ROUND;
    return sat(p >>> mod_pkg::R_FRAC);
  endfunction : rmul
  // complex rotation by the selected fraction of the local rate
  function automatic logic [27:0] mix(input logic [13:0] i, input logic [13:0] q,
                                      input mod_pkg::shift_e m, input logic [2:0] st);
    logic [13:0] oi;
    logic [13:0] oq;
    oi = i;
    oq = q;
    unique case (m)
      mod_pkg::shift_half: begin
        if (st[0]) begin
          oi = neg(i);
          oq = neg(q);
        end
      end
      mod_pkg::shift_quarter: begin
        unique case (st[1:0])
          2'h0: begin oi = i; oq = q; end
          2'h1: begin oi = q; oq = neg(i); end
          2'h2: begin oi = neg(i); oq = neg(q); end
          2'h3: begin oi = neg(q); oq = i; end
        endcase
      end
      mod_pkg::shift_three_quarter: begin
        unique case (st[1:0])
          2'h0: begin oi = i; oq = q; end
          2'h1: begin oi = neg(q); oq = i; end
          2'h2: begin oi = neg(i); oq = neg(q); end
          2'h3: begin oi = q; oq = neg(i); end
        endcase
      end
      mod_pkg::shift_eighth: begin
        unique case (st)
          3'h0: begin oi = i; oq = q; end
          3'h1: begin oi = rmul(sx(i) + sx(q)); oq = rmul(sx(q) - sx(i)); end
          3'h2: begin oi = q; oq = neg(i); end
          3'h3: begin oi = rmul(sx(q) - sx(i)); oq = rmul(-sx(q) - sx(i)); end
          3'h4: begin oi = neg(i); oq = neg(q); end
          3'h5: begin oi = rmul(-sx(i) - sx(q)); oq = rmul(sx(i) - sx(q)); end
          3'h6: begin oi = neg(q); oq = i; end
          3'h7: begin oi = rmul(sx(i) - sx(q)); oq = rmul(sx(q) + sx(i)); end
        endcase
      end
      default: begin
      end
    endcase
    return {oi, oq};
  endfunction : mix
  // stage mode m centres the stage at m quarters of its output rate
  function automatic mod_pkg::shift_e stage_shift(input logic [1:0] m);
    unique case (m)
      2'h0: return mod_pkg::shift_none;
      2'h1: return mod_pkg::shift_quarter;
      2'h2: return mod_pkg::shift_half;
      2'h3: return mod_pkg::shift_three_quarter;
    endcase
  endfunction : stage_shift
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0][1:0] hb_mode;
    logic [2:0] hb_en;
    mod_pkg::shift_e shift;
    mod_pkg::shift_e shift_prev;
    logic premod;
    logic nco_en;
    logic [31:0] ftw_wr;
    logic [31:0] ftw_act;
    logic upd;
    logic [13:0] asm_i;
    logic [13:0] asm_q;
    logic [1:0] beat;
    logic pair_ok;
    logic [13:0] raw_i;
    logic [13:0] raw_q;
    logic [13:0] hold_i;
    logic [13:0] hold_q;
    logic [2:0] cnt;
    logic [2:0] cstep;
    logic pstep;
    logic [2:0][1:0] sstep;
    logic [31:0] phase;
    logic [13:0] out_i;
    logic [13:0] out_q;
    logic taken;
  } dev_state_s;
  dev_state_s state_ff;
  dev_state_s nxt_state;
  assign link.smp_ready = !state_ff.pair_ok;
  assign dac_i = state_ff.out_i;
  assign dac_q = state_ff.out_q;
  assign sample_taken = state_ff.taken;
  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [2:0] lmask;
    logic [1:0] pos;
    logic tick_in;
    logic tick_s;
    logic nco_tick;
    logic [27:0] v;
    logic [1:0] last;
    lmask = 3'h0;
    pos = 2'h0;
    tick_in = state_ff.cnt == 3'h0;
    tick_s = 1'b0;
    nco_tick = 1'b0;
    v = 28'h0;
    last = link.byte_mode ? mod_pkg::BYTE_LAST_BEAT : mod_pkg::WORD_LAST_BEAT;
    nxt_state = state_ff;
    nxt_state.taken = 1'b0;
    // config port; tuning word bytes land in the shadow copy only
    if (link.cfg_we) begin
      for (int s = 0; s < 3; s++) begin
        if (link.cfg_addr == mod_pkg::REG_HB1 + 8'(s)) begin
          nxt_state.hb_mode[s] = link.cfg_wdata[mod_pkg::HB_MODE_LSB +: 2];
          nxt_state.hb_en[s] = link.cfg_wdata[mod_pkg::HB_EN_BIT];
        end
      end
      for (int b = 0; b < 4; b++) begin
        if (link.cfg_addr == mod_pkg::REG_FTW0 + 8'(b)) begin
          nxt_state.ftw_wr[8*b +: 8] = link.cfg_wdata;
        end
      end
      if (link.cfg_addr == mod_pkg::REG_SHIFT) begin
        nxt_state.shift = mod_pkg::shift_e'(link.cfg_wdata[mod_pkg::SHIFT_MODE_LSB +: 3]);
        nxt_state.premod = link.cfg_wdata[mod_pkg::PREMOD_BIT];
        nxt_state.nco_en = link.cfg_wdata[mod_pkg::NCO_EN_BIT];
      end
      if (link.cfg_addr == mod_pkg::REG_UPDATE) begin
        nxt_state.upd = link.cfg_wdata[mod_pkg::UPDATE_BIT];
        if (link.cfg_wdata[mod_pkg::UPDATE_BIT] && !state_ff.upd) begin
          nxt_state.ftw_act = state_ff.ftw_wr;
        end
      end
    end
    // sample assembly: a beat marked first always restarts the pair
    if (link.smp_valid && !state_ff.pair_ok) begin
      nxt_state.beat = link.smp_first ? 2'h0 : state_ff.beat;
      if (link.byte_mode) begin
        unique case (nxt_state.beat)
          2'h0: nxt_state.asm_i[13:mod_pkg::BYTE_HI_LSB] = link.smp_data[7:0];
          2'h1: nxt_state.asm_i[mod_pkg::BYTE_HI_LSB-1:0] = link.smp_data[5:0];
          2'h2: nxt_state.asm_q[13:mod_pkg::BYTE_HI_LSB] = link.smp_data[7:0];
          2'h3: nxt_state.asm_q[mod_pkg::BYTE_HI_LSB-1:0] = link.smp_data[5:0];
        endcase
      end else if (nxt_state.beat == 2'h0) begin
        nxt_state.asm_i = link.smp_data;
      end else begin
        nxt_state.asm_q = link.smp_data;
      end
      if (nxt_state.beat == last) begin
        nxt_state.pair_ok = 1'b1;
        nxt_state.beat = 2'h0;
      end else begin
        nxt_state.beat = nxt_state.beat + 2'h1;
      end
    end
    // rate counter: one input sample every 2^n cycles, n stages on
    for (int s = 0; s < 3; s++) begin
      if (state_ff.hb_en[s]) begin
        lmask = {lmask[1:0], 1'b1};
      end
    end
    nxt_state.cnt = (state_ff.cnt + 3'h1) & lmask;
    if (state_ff.shift != state_ff.shift_prev) begin
      nxt_state.shift_prev = state_ff.shift;
      nxt_state.cstep = 3'h0;
    end else if (tick_in) begin
      // underrun repeats the last pair rather than inserting zeros
      if (state_ff.pair_ok) begin
        nxt_state.raw_i = state_ff.asm_i;
        nxt_state.raw_q = state_ff.asm_q;
        nxt_state.pair_ok = 1'b0;
        nxt_state.taken = 1'b1;
      end
      v = mix(nxt_state.raw_i, nxt_state.raw_q, state_ff.shift, state_ff.cstep);
      if (state_ff.premod) begin
        v = mix(v[27:14], v[13:0], mod_pkg::shift_half, {2'h0, state_ff.pstep});
      end
      nxt_state.hold_i = v[27:14];
      nxt_state.hold_q = v[13:0];
      nxt_state.cstep = state_ff.cstep + 3'h1;
      nxt_state.pstep = !state_ff.pstep;
    end
    // stage chain, each rotating at its own output rate
    v = {state_ff.hold_i, state_ff.hold_q};
    nco_tick = tick_in;
    for (int s = 0; s < 3; s++) begin
      if (state_ff.hb_en[s]) begin
        pos = pos + 2'h1;
        tick_s = (state_ff.cnt & (lmask >> pos)) == 3'h0;
        v = mix(v[27:14], v[13:0], stage_shift(state_ff.hb_mode[s]),
                {1'b0, state_ff.sstep[s]});
        if (tick_s) begin
          nxt_state.sstep[s] = state_ff.sstep[s] + 2'h1;
        end
        if (s == 0) begin
          nco_tick = tick_s;
        end
      end
      // oscillator sits after the first stage; quadrant rotation only
      if (s == 0 && state_ff.nco_en) begin
        v = mix(v[27:14], v[13:0], mod_pkg::shift_quarter, {1'b0, state_ff.phase[31:30]});
      end
    end
    if (nco_tick) begin
      nxt_state.phase = state_ff.phase + state_ff.ftw_act;
    end
    nxt_state.out_i = v[27:14];
    nxt_state.out_q = v[13:0];
  end
  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      state_ff <= '0;
      state_ff.hb_en <= mod_pkg::HB_EN_RESET;
      state_ff.ftw_wr <= mod_pkg::FTW_RESET;
      state_ff.ftw_act <= mod_pkg::FTW_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end
endmodule : coarse_modulator

//--- verilog/mod_pkg.sv
package mod_pkg;
  // ----------------------------------------------------------------
  // sample widths and fixed-point constants
  // ----------------------------------------------------------------
  localparam int SW = 14;
  localparam int FW = 32;
  localparam logic signed [15:0] R_COEF = 16'sh16a1;
  localparam int R_FRAC = 13;
  localparam logic signed [31:0] R_ROUND = 32'sh0000_1000;
  localparam logic signed [31:0] SAT_MAX = 32'sh0000_1fff;
  localparam logic signed [31:0] SAT_MIN = -32'sh0000_2000;
  // ----------------------------------------------------------------
  // device configuration map, reached over the link config port
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_HB1 = 8'h1c;
  localparam logic [7:0] REG_HB2 = 8'h1d;
  localparam logic [7:0] REG_HB3 = 8'h1e;
  localparam logic [7:0] REG_SHIFT = 8'h1f;
  localparam logic [7:0] REG_FTW0 = 8'h30;
  localparam logic [7:0] REG_UPDATE = 8'h36;
  localparam int HB_MODE_LSB = 0;
  localparam int HB_EN_BIT = 7;
  localparam int SHIFT_MODE_LSB = 0;
  localparam int PREMOD_BIT = 3;
  localparam int NCO_EN_BIT = 4;
  localparam int UPDATE_BIT = 0;
  localparam logic [2:0] HB_EN_RESET = 3'h0;
  localparam logic [FW-1:0] FTW_RESET = 32'h0000_0000;
  // ----------------------------------------------------------------
  // sample bus framing
  // ----------------------------------------------------------------
  localparam int BYTE_HI_LSB = 6;
  localparam logic [1:0] WORD_LAST_BEAT = 2'h1;
  localparam logic [1:0] BYTE_LAST_BEAT = 2'h3;
  // ----------------------------------------------------------------
  // host apb map
  // ----------------------------------------------------------------
  localparam logic [11:0] APB_CTRL = 12'h000;
  localparam logic [11:0] APB_SAMPLE = 12'h004;
  localparam logic [11:0] APB_CFG = 12'h008;
  localparam logic [11:0] APB_STATUS = 12'h00c;
  localparam int CTRL_BYTE_BIT = 0;
  localparam int SMP_I_LSB = 0;
  localparam int SMP_Q_LSB = 16;
  localparam int CFG_DATA_LSB = 0;
  localparam int CFG_ADDR_LSB = 8;
  localparam int STAT_BUSY_BIT = 0;

  typedef enum logic [2:0] {
    shift_none, shift_half, shift_quarter, shift_three_quarter, shift_eighth
  } shift_e;
endpackage : mod_pkg

//--- verilog/mod_link_if.sv
`timescale 1ns/10ps
interface mod_link_if (
  input wire logic pclk,
  input wire logic presetn
);
  logic byte_mode;
  logic smp_valid;
  logic smp_ready;
  logic smp_first;
  logic [13:0] smp_data;
  logic cfg_we;
  logic [7:0] cfg_addr;
  logic [7:0] cfg_wdata;

  modport dev (
    input pclk, presetn, byte_mode, smp_valid, smp_first, smp_data,
    input cfg_we, cfg_addr, cfg_wdata,
    output smp_ready
  );
  modport host (
    input pclk, presetn, smp_ready,
    output byte_mode, smp_valid, smp_first, smp_data, cfg_we, cfg_addr, cfg_wdata
  );
endinterface : mod_link_if

//--- verilog/sample_host.sv
`timescale 1ns/10ps
module sample_host (
  mod_link_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ----------------------------------------------------------------
  // beat formatting
  // ----------------------------------------------------------------
  function automatic logic [13:0] beat_word(input logic [27:0] smp, input logic [1:0] idx,
                                            input logic byte_mode);
    logic [13:0] i;
    logic [13:0] q;
    i = smp[13:0];
    q = smp[27:14];
    if (!byte_mode) begin
      return idx[0] ? q : i;
    end
    unique case (idx)
      2'h0: return {6'h00, i[13:mod_pkg::BYTE_HI_LSB]};
      2'h1: return {8'h00, i[mod_pkg::BYTE_HI_LSB-1:0]};
      2'h2: return {6'h00, q[13:mod_pkg::BYTE_HI_LSB]};
      default: return {8'h00, q[mod_pkg::BYTE_HI_LSB-1:0]};
    endcase
  endfunction : beat_word

  typedef struct packed {
    logic byte_mode;
    logic busy;
    logic [1:0] idx;
    logic [27:0] smp;
    logic [13:0] data;
    logic cfg_we;
    logic [7:0] cfg_addr;
    logic [7:0] cfg_wdata;
  } host_state_s;

  host_state_s state_ff;
  host_state_s nxt_state;
  logic access;
  logic mapped;

  assign access = psel && penable;
  assign mapped = paddr == mod_pkg::APB_CTRL || paddr == mod_pkg::APB_SAMPLE ||
                  paddr == mod_pkg::APB_CFG || paddr == mod_pkg::APB_STATUS;
  // a new pair waits while the previous one is still on the bus
  assign pready = !(pwrite && paddr == mod_pkg::APB_SAMPLE && state_ff.busy);
  assign pslverr = access && !mapped;
  assign link.byte_mode = state_ff.byte_mode;
  assign link.smp_valid = state_ff.busy;
  assign link.smp_first = state_ff.idx == 2'h0;
  assign link.smp_data = state_ff.data;
  assign link.cfg_we = state_ff.cfg_we;
  assign link.cfg_addr = state_ff.cfg_addr;
  assign link.cfg_wdata = state_ff.cfg_wdata;

  always_comb begin
    prdata = 32'h0000_0000;
    if (paddr == mod_pkg::APB_CTRL) begin
      prdata[mod_pkg::CTRL_BYTE_BIT] = state_ff.byte_mode;
    end else if (paddr == mod_pkg::APB_STATUS) begin
      prdata[mod_pkg::STAT_BUSY_BIT] = state_ff.busy;
    end
  end

  always_comb begin
    logic [1:0] last;
    last = state_ff.byte_mode ? mod_pkg::BYTE_LAST_BEAT : mod_pkg::WORD_LAST_BEAT;
    nxt_state = state_ff;
    nxt_state.cfg_we = 1'b0;
    if (state_ff.busy && link.smp_ready) begin
      if (state_ff.idx == last) begin
        nxt_state.busy = 1'b0;
        nxt_state.idx = 2'h0;
      end else begin
        nxt_state.idx = state_ff.idx + 2'h1;
        nxt_state.data = beat_word(state_ff.smp, nxt_state.idx, state_ff.byte_mode);
      end
    end
    if (access && pwrite && pready) begin
      unique case (paddr)
        mod_pkg::APB_CTRL: begin
          // changing bus width mid-pair would split a sample
          if (!state_ff.busy) begin
            nxt_state.byte_mode = pwdata[mod_pkg::CTRL_BYTE_BIT];
          end
        end
        mod_pkg::APB_SAMPLE: begin
          nxt_state.smp = {pwdata[mod_pkg::SMP_Q_LSB +: 14], pwdata[mod_pkg::SMP_I_LSB +: 14]};
          nxt_state.busy = 1'b1;
          nxt_state.idx = 2'h0;
          nxt_state.data = beat_word(nxt_state.smp, 2'h0, state_ff.byte_mode);
        end
        mod_pkg::APB_CFG: begin
          nxt_state.cfg_we = 1'b1;
          nxt_state.cfg_addr = pwdata[mod_pkg::CFG_ADDR_LSB +: 8];
          nxt_state.cfg_wdata = pwdata[mod_pkg::CFG_DATA_LSB +: 8];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge link.pclk or negedge link.presetn) begin
    if (!link.presetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end
endmodule : sample_host

//--- tb/mod_link_chk.sv
`timescale 1ns/10ps
module mod_link_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic byte_mode,
  input wire logic smp_valid,
  input wire logic smp_ready,
  input wire logic smp_first,
  input wire logic [13:0] smp_data,
  input wire logic cfg_we,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata
);
  // ----------------------------------------------------------------
  // beat position inside the current pair
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] pos;
  } chk_s;
  chk_s st_ff;
  chk_s nxt_st;
  logic take;
  logic [1:0] last;
  assign take = smp_valid & smp_ready;
  assign last = byte_mode ? mod_pkg::BYTE_LAST_BEAT : mod_pkg::WORD_LAST_BEAT;
  always_comb begin
    nxt_st = st_ff;
    if (take) begin
      nxt_st.pos = (st_ff.pos == last) ? 2'h0 : st_ff.pos + 2'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  // ----------------------------------------------------------------
  // link properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  hold_beat_a: assert property (smp_valid && !smp_ready |=> smp_valid
    && $stable(smp_data) && $stable(smp_first)) else $error("beat changed before it was taken");
  first_flag_a: assert property (take |-> smp_first == (st_ff.pos == 2'h0))
    else $error("first flag not on beat zero");
  ready_drop_a: assert property (take && st_ff.pos == last |=> !smp_ready)
    else $error("ready stayed high after a full pair");
  valid_drop_a: assert property (take && st_ff.pos == last |=> !smp_valid)
    else $error("host kept valid after a full pair");
  valid_fall_a: assert property ($fell(smp_valid) |-> $past(take))
    else $error("valid released without a take");
  mode_hold_a: assert property (smp_valid |=> $stable(byte_mode))
    else $error("bus width changed inside a pair");
  cfg_pulse_a: assert property (cfg_we |=> !cfg_we)
    else $error("config strobe longer than one cycle");
  ready_back_a: assert property ($fell(smp_ready) |-> ##[1:24] smp_ready)
    else $error("ready not restored by the input tick");
  cover property (take && byte_mode && st_ff.pos == 2'h3);
  cover property (take && !byte_mode && st_ff.pos == 2'h1);
  cover property (cfg_we && cfg_addr == mod_pkg::REG_UPDATE);
endmodule : mod_link_chk

//--- tb/testbench.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [13:0] dac_i;
  logic [13:0] dac_q;
  logic sample_taken;
  logic [13:0] cap_i[16];
  logic [13:0] cap_q[16];
  logic [31:0] rd;
  logic er;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  int taken_cnt = 0;
  int smp_count = 0;
  logic pre_on = 1'b0;
  always #2.5 pclk = ~pclk;
  mod_link_if link_i (.pclk(pclk), .presetn(presetn));
  coarse_modulator coarse_modulator_i (.link(link_i), .dac_i(dac_i), .dac_q(dac_q),
    .sample_taken(sample_taken));
  sample_host sample_host_i (.link(link_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  mod_link_chk mod_link_chk_i (.pclk(pclk), .presetn(presetn), .byte_mode(link_i.byte_mode),
    .smp_valid(link_i.smp_valid), .smp_ready(link_i.smp_ready), .smp_first(link_i.smp_first),
    .smp_data(link_i.smp_data), .cfg_we(link_i.cfg_we), .cfg_addr(link_i.cfg_addr),
    .cfg_wdata(link_i.cfg_wdata));
  // ----------------------------------------------------------------
  // bus tasks and helpers
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  // a hung transfer is cut short here rather than inside the bus task
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      close_out();
    end
  end
  // every consumed pair should show exactly one taken pulse
  always @(posedge pclk) begin
    if (sample_taken === 1'b1) begin
      taken_cnt <= taken_cnt + 1;
    end
  end
  // pready is looked at on the rising edge, where the slave samples the access
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic cfg(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, mod_pkg::APB_CFG, {16'h0000, a, d});
  endtask : cfg
  task automatic smp(input int i, input int q);
    smp_count++;
    apb(1'b1, mod_pkg::APB_SAMPLE, {2'h0, q[13:0], 2'h0, i[13:0]});
  endtask : smp
  task automatic grab();
    repeat (12) @(posedge pclk);
    for (int k = 0; k < 16; k++) begin
      @(negedge pclk);
      cap_i[k] = dac_i;
      cap_q[k] = dac_q;
    end
  endtask : grab
  function automatic int rr(input int x);
    int p;
    p = (x * int'(mod_pkg::R_COEF) + int'(mod_pkg::R_ROUND)) >>> mod_pkg::R_FRAC;
    if (p > int'(mod_pkg::SAT_MAX)) p = int'(mod_pkg::SAT_MAX);
    if (p < int'(mod_pkg::SAT_MIN)) p = int'(mod_pkg::SAT_MIN);
    return p;
  endfunction : rr
  function automatic void step(input mod_pkg::shift_e m, input int k, input int i, input int q,
    output int ei, output int eq);
    int a[8];
    int b[8];
    int p;
    p = 4;
    a = '{0: i, default: i};
    b = '{0: q, default: q};
    case (m)
      mod_pkg::shift_half: begin
        a = '{0: i, 1: -i, 2: i, 3: -i, default: 0};
        b = '{0: q, 1: -q, 2: q, 3: -q, default: 0};
      end
      mod_pkg::shift_quarter: begin
        a = '{0: i, 1: q, 2: -i, 3: -q, default: 0};
        b = '{0: q, 1: -i, 2: -q, 3: i, default: 0};
      end
      mod_pkg::shift_three_quarter: begin
        a = '{0: i, 1: -q, 2: -i, 3: q, default: 0};
        b = '{0: q, 1: i, 2: -q, 3: -i, default: 0};
      end
      mod_pkg::shift_eighth: begin
        a = '{i, rr(i + q), q, rr(q - i), -i, -rr(i + q), -q, rr(i - q)};
        b = '{q, rr(q - i), -i, -rr(q + i), -q, rr(i - q), i, rr(q + i)};
        p = 8;
      end
      default: p = 1;
    endcase
    ei = a[k % p];
    eq = b[k % p];
  endfunction : step
  function automatic int negs();
    int c;
    c = 0;
    for (int k = 0; k < 16; k++) if (cap_i[k] === 14'h3c18) c++;
    return c;
  endfunction : negs
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // output phase is found from step zero, then n steps are compared in order
  task automatic run_shift(input mod_pkg::shift_e m, input int i, input int q, input int n);
    int ei;
    int eq;
    int j;
    logic [13:0] xi;
    logic [13:0] xq;
    mod_pkg::shift_e em;
    // premodulation alone is a half-rate flip, so it is only run with no coarse shift
    em = pre_on ? mod_pkg::shift_half : m;
    cfg(mod_pkg::REG_SHIFT, {4'h0, pre_on, m});
    smp(i, q);
    grab();
    step(em, 0, i, q, ei, eq);
    j = 0;
    for (int s = 7; s >= 0; s--) if (cap_i[s] === ei[13:0] && cap_q[s] === eq[13:0]) j = s;
    for (int k = 0; k < n; k++) begin
      step(em, k, i, q, ei, eq);
      xi = ei[13:0];
      xq = eq[13:0];
      `CHK("dac_i", xi, cap_i[j + k])
      `CHK("dac_q", xq, cap_q[j + k])
    end
  endtask : run_shift
  task automatic stage_check(input int lo);
    int chg;
    grab();
    chg = 0;
    for (int k = 1; k < 16; k++) if (cap_i[k] !== cap_i[k - 1]) chg++;
    `CHK("dac_i change count", 1'b1, (chg == lo || chg == lo + 1))
  endtask : stage_check
  task automatic run_nco();
    cfg(mod_pkg::REG_SHIFT, 8'h10);
    cfg(mod_pkg::REG_FTW0 + 8'h03, 8'h40);
    smp(1000, 300);
    grab();
    `CHK("turns before update", 0, negs())
    cfg(mod_pkg::REG_UPDATE, 8'h00);
    cfg(mod_pkg::REG_UPDATE, 8'h01);
    grab();
    // a quarter-turn word shows -I on exactly one sample in four
    `CHK("turns after update", 4, negs())
  endtask : run_nco
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h010, 32'h0000_0000);
    `CHK("unmapped error", 1'b1, er)
    `CHK("unmapped data", 32'h0000_0000, rd)
    apb(1'b0, mod_pkg::APB_STATUS, 32'h0000_0000);
    `CHK("idle busy", 1'b0, rd[0])
    run_shift(mod_pkg::shift_none, 1000, 300, 4);
    pre_on = 1'b1;
    run_shift(mod_pkg::shift_none, 500, 200, 4);
    pre_on = 1'b0;
    run_shift(mod_pkg::shift_half, 1000, 300, 8);
    run_shift(mod_pkg::shift_quarter, 1000, 300, 8);
    run_shift(mod_pkg::shift_three_quarter, 1000, 300, 8);
    run_shift(mod_pkg::shift_eighth, 1000, 300, 8);
    // full-scale pair pushes the r product past the top code
    run_shift(mod_pkg::shift_eighth, 8191, 8191, 2);
    run_shift(mod_pkg::shift_quarter, 1000, 300, 4);
    cfg(mod_pkg::REG_HB1, 8'h80);
    stage_check(7);
    cfg(mod_pkg::REG_HB2, 8'h80);
    stage_check(3);
    cfg(mod_pkg::REG_HB1, 8'h00);
    cfg(mod_pkg::REG_HB2, 8'h00);
    run_nco();
    apb(1'b1, mod_pkg::APB_CTRL, 32'h0000_0001);
    apb(1'b0, mod_pkg::APB_CTRL, 32'h0000_0000);
    `CHK("bus width", 1'b1, rd[0])
    run_shift(mod_pkg::shift_none, -1234, 777, 2);
    `CHK("pairs taken", smp_count, taken_cnt)
    close_out();
  end
endmodule : testbench
